// *** design/snc_consts.svh ***
// Opcodes, phase figures and link timing counts of the serial NOR command decoder
`ifndef SNC_CONSTS_SVH
`define SNC_CONSTS_SVH

// ------------------------------------------------------------------
// Opcodes
// ------------------------------------------------------------------
`define SNC_OP_RSTEN 8'h66
`define SNC_OP_RSTMEM 8'h99
`define SNC_OP_ID_A 8'h9E
`define SNC_OP_ID_B 8'h9F
`define SNC_OP_ID_MULTI 8'hAF
`define SNC_OP_DISCOVER 8'h5A
`define SNC_OP_READ 8'h03
`define SNC_OP_FAST 8'h0B
`define SNC_OP_DOUT 8'h3B
`define SNC_OP_DIO 8'hBB
`define SNC_OP_QOUT 8'h6B
`define SNC_OP_QIO 8'hEB
`define SNC_OP_DTR_DOUT 8'h3D
`define SNC_OP_DTR_DIO 8'hBD
`define SNC_OP_DTR_QOUT 8'h6D
`define SNC_OP_DTR_QIO 8'hED
`define SNC_OP_READ4 8'h13
`define SNC_OP_FAST4 8'h0C
`define SNC_OP_DOUT4 8'h3C
`define SNC_OP_QOUT4 8'h6C
`define SNC_OP_DTR4 8'h0E
`define SNC_OP_DTR_DIO4 8'hBE
`define SNC_OP_DTR_QIO4 8'hEE
`define SNC_OP_WREN 8'h06
`define SNC_OP_WRDI 8'h04
`define SNC_OP_RD_STAT 8'h05
`define SNC_OP_RD_FLAG 8'h70
`define SNC_OP_RD_NVCFG 8'hB5
`define SNC_OP_RD_VCFG 8'h85
`define SNC_OP_RD_EVCFG 8'h65
`define SNC_OP_RD_EXTADR 8'hC8
`define SNC_OP_RD_GP 8'h96
`define SNC_OP_WR_STAT 8'h01
`define SNC_OP_WR_NVCFG 8'hB1

// ------------------------------------------------------------------
// Lane counts, address bytes, dummy clocks
// ------------------------------------------------------------------
`define SNC_LANE0 3'h0
`define SNC_LANE1 3'h1
`define SNC_LANE2 3'h2
`define SNC_LANE4 3'h4
`define SNC_ABYTES0 3'h0
`define SNC_ABYTES3 3'h3
`define SNC_ABYTES4 3'h4
`define SNC_DUMMY0 4'h0
`define SNC_DUMMY6 4'h6
`define SNC_DUMMY8 4'h8
`define SNC_DUMMY10 4'hA

// ------------------------------------------------------------------
// Link sampling: edge count cap and sample groups needed for the command byte per lane width
// ------------------------------------------------------------------
`define SNC_EDGES_MAX 4'h8
`define SNC_STAGE_QUAD 2'h1
`define SNC_STAGE_DUAL 2'h2
`define SNC_STAGE_EXT 2'h3

`endif

// *** design/snc_decoder.sv ***
// Serial NOR command decoder: link-side byte capture and system-side decode
`timescale 1ns/1ps
`include "snc_consts.svh"

module snc_decoder
    import snc_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire snc_mode_e mode,
    input wire logic four_byte_addr,
    input wire logic link_sclk,
    input wire logic link_cs_n,
    input wire logic [3:0] link_dq_in,
    output snc_cmd_s cmd_out,
    output logic cmd_valid,
    output logic cmd_ignored,
    output logic write_enable_latch,
    output logic soft_reset
);

    // ------------------------------------------------------------------
    // Decode table
    // ------------------------------------------------------------------
    function automatic snc_cmd_s snc_decode(input logic [7:0] op, input snc_mode_e md,
                                            input logic fourb, output logic ok);
        logic ok_e;
        logic ok_d;
        logic ok_q;
        logic [2:0] ea;
        logic [2:0] ed;
        logic [2:0] w;
        snc_asel_e asel;
        logic [3:0] de;
        logic [3:0] dd;
        logic [3:0] dq;
        snc_cmd_s r;
        ok_e = 1'b1;
        ok_d = 1'b1;
        ok_q = 1'b1;
        ea = `SNC_LANE1;
        ed = `SNC_LANE1;
        asel = SNC_ASEL_VAR;
        de = `SNC_DUMMY8;
        dd = `SNC_DUMMY8;
        dq = `SNC_DUMMY10;
        r = '0;
        r.opcode = op;
        r.kind = SNC_KIND_READ;
        unique case (op)
            `SNC_OP_RSTEN, `SNC_OP_RSTMEM, `SNC_OP_WREN, `SNC_OP_WRDI: begin
                asel = SNC_ASEL_NONE;
                ed = `SNC_LANE0;
                {de, dd, dq} = '0;
                r.kind = (op == `SNC_OP_RSTEN) ? SNC_KIND_RSTEN :
                         (op == `SNC_OP_RSTMEM) ? SNC_KIND_RSTMEM :
                         (op == `SNC_OP_WREN) ? SNC_KIND_WREN : SNC_KIND_WRDI;
            end
            `SNC_OP_ID_MULTI, `SNC_OP_ID_A, `SNC_OP_ID_B: begin
                asel = SNC_ASEL_NONE;
                {de, dd, dq} = '0;
                r.kind = SNC_KIND_ID;
                ok_d = (op == `SNC_OP_ID_MULTI);
                ok_q = (op == `SNC_OP_ID_MULTI);
            end
            `SNC_OP_DISCOVER: begin
                asel = SNC_ASEL_THREE;
                dq = `SNC_DUMMY8;
                r.kind = SNC_KIND_DISCOVER;
            end
            `SNC_OP_READ, `SNC_OP_READ4: begin
                {de, dd, dq} = '0;
                ok_d = 1'b0;
                ok_q = 1'b0;
                if (op == `SNC_OP_READ4) begin
                    asel = SNC_ASEL_FOUR;
                end
            end
            `SNC_OP_FAST: begin
            end
            `SNC_OP_FAST4: begin
                asel = SNC_ASEL_FOUR;
            end
            `SNC_OP_DOUT, `SNC_OP_DOUT4: begin
                ed = `SNC_LANE2;
                ok_q = 1'b0;
                if (op == `SNC_OP_DOUT4) begin
                    asel = SNC_ASEL_FOUR;
                end
            end
            `SNC_OP_DIO: begin
                ea = `SNC_LANE2;
                ed = `SNC_LANE2;
                ok_q = 1'b0;
            end
            `SNC_OP_QOUT, `SNC_OP_QOUT4: begin
                ed = `SNC_LANE4;
                ok_d = 1'b0;
                if (op == `SNC_OP_QOUT4) begin
                    asel = SNC_ASEL_FOUR;
                end
            end
            `SNC_OP_QIO: begin
                ea = `SNC_LANE4;
                ed = `SNC_LANE4;
                de = `SNC_DUMMY10;
                ok_d = 1'b0;
            end
            `SNC_OP_DTR_DOUT, `SNC_OP_DTR_DIO, `SNC_OP_DTR_DIO4: begin
                r.dtr = 1'b1;
                ed = `SNC_LANE2;
                ea = (op == `SNC_OP_DTR_DOUT) ? `SNC_LANE1 : `SNC_LANE2;
                de = `SNC_DUMMY6;
                dd = `SNC_DUMMY6;
                ok_q = 1'b0;
                if (op == `SNC_OP_DTR_DIO4) begin
                    asel = SNC_ASEL_FOUR;
                end
            end
            `SNC_OP_DTR_QOUT: begin
                r.dtr = 1'b1;
                ed = `SNC_LANE4;
                de = `SNC_DUMMY6;
                dq = `SNC_DUMMY8;
                ok_d = 1'b0;
            end
            `SNC_OP_DTR_QIO, `SNC_OP_DTR_QIO4: begin
                r.dtr = 1'b1;
                ea = `SNC_LANE4;
                ed = `SNC_LANE4;
                dq = `SNC_DUMMY8;
                ok_d = 1'b0;
                if (op == `SNC_OP_DTR_QIO4) begin
                    asel = SNC_ASEL_FOUR;
                end
            end
            `SNC_OP_DTR4: begin
                r.dtr = 1'b1;
                asel = SNC_ASEL_FOUR;
                de = `SNC_DUMMY6;
                dd = `SNC_DUMMY6;
                dq = `SNC_DUMMY8;
            end
            `SNC_OP_RD_STAT, `SNC_OP_RD_FLAG, `SNC_OP_RD_NVCFG, `SNC_OP_RD_VCFG,
            `SNC_OP_RD_EVCFG, `SNC_OP_RD_EXTADR: begin
                asel = SNC_ASEL_NONE;
                {de, dd, dq} = '0;
                r.kind = SNC_KIND_REG_READ;
            end
            `SNC_OP_RD_GP: begin
                asel = SNC_ASEL_NONE;
                dq = `SNC_DUMMY8;
                r.kind = SNC_KIND_REG_READ;
            end
            `SNC_OP_WR_STAT, `SNC_OP_WR_NVCFG: begin
                asel = SNC_ASEL_NONE;
                {de, dd, dq} = '0;
                r.kind = SNC_KIND_REG_WRITE;
            end
            default: begin
                ok_e = 1'b0;
                ok_d = 1'b0;
                ok_q = 1'b0;
            end
        endcase
        // Dual and quad modes run every phase on the mode's full width
        unique case (md)
            SNC_MODE_DUAL: begin
                w = `SNC_LANE2;
                ok = ok_d;
                r.dummy = dd;
            end
            SNC_MODE_QUAD: begin
                w = `SNC_LANE4;
                ok = ok_q;
                r.dummy = dq;
            end
            default: begin
                w = `SNC_LANE1;
                ok = ok_e;
                r.dummy = de;
            end
        endcase
        r.cmd_lanes = w;
        r.addr_lanes = (asel == SNC_ASEL_NONE) ? `SNC_LANE0 :
                       (md == SNC_MODE_EXT) ? ea : w;
        r.data_lanes = (ed == `SNC_LANE0) ? `SNC_LANE0 : (md == SNC_MODE_EXT) ? ed : w;
        unique case (asel)
            SNC_ASEL_NONE: r.addr_bytes = `SNC_ABYTES0;
            SNC_ASEL_THREE: r.addr_bytes = `SNC_ABYTES3;
            SNC_ASEL_FOUR: r.addr_bytes = `SNC_ABYTES4;
            default: r.addr_bytes = fourb ? `SNC_ABYTES4 : `SNC_ABYTES3;
        endcase
        if (!ok) begin
            r.kind = SNC_KIND_NONE;
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Link domain: first eight edges of the frame
    // ------------------------------------------------------------------
    logic [3:0] edge_cnt_reg;
    logic [3:0] sample_reg [8];
    logic stage_tgl_reg;

    // Chip select high clears the edge count without needing a link edge
    always_ff @(posedge link_sclk or posedge link_cs_n) begin
        if (link_cs_n) begin
            edge_cnt_reg <= 4'h0;
        end else if (edge_cnt_reg != `SNC_EDGES_MAX) begin
            edge_cnt_reg <= edge_cnt_reg + 4'h1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sample
            // Samples are not cleared at frame end, so the decode can still read them
            always_ff @(posedge link_sclk) begin
                if (!link_cs_n && edge_cnt_reg == 4'(gi)) begin
                    sample_reg[gi] <= link_dq_in;
                end
            end
        end
    endgenerate

    // Toggle marks sample groups complete after edges 2, 4 and 8
    always_ff @(posedge link_sclk or negedge nrst) begin
        if (!nrst) begin
            stage_tgl_reg <= 1'b0;
        end else if (!link_cs_n && (edge_cnt_reg == 4'h1 || edge_cnt_reg == 4'h3 ||
                                    edge_cnt_reg == 4'h7)) begin
            stage_tgl_reg <= ~stage_tgl_reg;
        end
    end

    // ------------------------------------------------------------------
    // System domain: crossing
    // ------------------------------------------------------------------
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic cs_s3_reg;
    logic tgl_s1_reg;
    logic tgl_s2_reg;
    logic tgl_s3_reg;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
            tgl_s1_reg <= 1'b0;
            tgl_s2_reg <= 1'b0;
            tgl_s3_reg <= 1'b0;
        end else begin
            cs_s1_reg <= link_cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
            tgl_s1_reg <= stage_tgl_reg;
            tgl_s2_reg <= tgl_s1_reg;
            tgl_s3_reg <= tgl_s2_reg;
        end
    end

    // ------------------------------------------------------------------
    // System domain: byte assembly and decode
    // ------------------------------------------------------------------
    logic frame_start;
    logic stage_evt;
    logic [1:0] stage_reg;
    logic [1:0] stage_need;
    logic done_reg;
    logic take;
    logic [7:0] op_byte;
    logic op_ok;
    snc_cmd_s dec;

    assign frame_start = cs_s3_reg && !cs_s2_reg;
    assign stage_evt = tgl_s2_reg ^ tgl_s3_reg;
    assign stage_need = (mode == SNC_MODE_QUAD) ? `SNC_STAGE_QUAD :
                        (mode == SNC_MODE_DUAL) ? `SNC_STAGE_DUAL : `SNC_STAGE_EXT;
    assign take = stage_evt && !done_reg && (stage_reg + 2'h1 == stage_need);

    always_ff @(posedge clock) begin
        if (!nrst || frame_start) begin
            stage_reg <= 2'h0;
            done_reg <= 1'b0;
        end else if (stage_evt) begin
            stage_reg <= stage_reg + 2'h1;
            done_reg <= done_reg | take;
        end
    end

    // Command bits arrive most significant first on the mode's lanes
    always_comb begin
        op_byte = 8'h00;
        unique case (mode)
            SNC_MODE_QUAD: op_byte = {sample_reg[0], sample_reg[1]};
            SNC_MODE_DUAL: op_byte = {sample_reg[0][1:0], sample_reg[1][1:0],
                                      sample_reg[2][1:0], sample_reg[3][1:0]};
            default: op_byte = {sample_reg[0][0], sample_reg[1][0], sample_reg[2][0],
                                sample_reg[3][0], sample_reg[4][0], sample_reg[5][0],
                                sample_reg[6][0], sample_reg[7][0]};
        endcase
        dec = snc_decode(op_byte, mode, four_byte_addr, op_ok);
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cmd_out <= '0;
            cmd_valid <= 1'b0;
            cmd_ignored <= 1'b0;
        end else begin
            cmd_valid <= take && op_ok;
            cmd_ignored <= take && !op_ok;
            if (take && op_ok) begin
                cmd_out <= dec;
            end
        end
    end

    // ------------------------------------------------------------------
    // System domain: reset sequence and write-enable latch
    // ------------------------------------------------------------------
    logic rst_armed_reg;

    // Any other accepted or ignored command in between disarms the reset
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rst_armed_reg <= 1'b0;
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= take && op_ok && dec.kind == SNC_KIND_RSTMEM && rst_armed_reg;
            if (take) begin
                rst_armed_reg <= op_ok && dec.kind == SNC_KIND_RSTEN;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst || soft_reset) begin
            write_enable_latch <= 1'b0;
        end else if (take && op_ok && dec.kind == SNC_KIND_WREN) begin
            write_enable_latch <= 1'b1;
        end else if (take && op_ok && dec.kind == SNC_KIND_WRDI) begin
            write_enable_latch <= 1'b0;
        end
    end

endmodule // snc_decoder

// *** design/snc_pkg.sv ***
// Types shared by the serial NOR command decoder
package snc_pkg;

    typedef enum logic [1:0] {
        SNC_MODE_EXT = 2'h0,
        SNC_MODE_DUAL = 2'h1,
        SNC_MODE_QUAD = 2'h2
    } snc_mode_e;

    typedef enum logic [3:0] {
        SNC_KIND_NONE = 4'h0,
        SNC_KIND_READ = 4'h1,
        SNC_KIND_ID = 4'h2,
        SNC_KIND_DISCOVER = 4'h3,
        SNC_KIND_REG_READ = 4'h4,
        SNC_KIND_REG_WRITE = 4'h5,
        SNC_KIND_WREN = 4'h6,
        SNC_KIND_WRDI = 4'h7,
        SNC_KIND_RSTEN = 4'h8,
        SNC_KIND_RSTMEM = 4'h9
    } snc_kind_e;

    typedef enum logic [1:0] {
        SNC_ASEL_NONE = 2'h0,
        SNC_ASEL_THREE = 2'h1,
        SNC_ASEL_FOUR = 2'h2,
        SNC_ASEL_VAR = 2'h3
    } snc_asel_e;

    typedef struct packed {
        logic [7:0] opcode;
        snc_kind_e kind;
        logic dtr;
        logic [2:0] cmd_lanes;
        logic [2:0] addr_lanes;
        logic [2:0] data_lanes;
        logic [2:0] addr_bytes;
        logic [3:0] dummy;
    } snc_cmd_s;

endpackage

// *** dv/snc_decoder_properties.sv ***
// Concurrent checks on the ports of the serial NOR command decoder
`timescale 1ns/1ps
`include "snc_consts.svh"
module snc_decoder_checker
    import snc_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire snc_mode_e mode,
    input wire logic four_byte_addr,
    input wire snc_cmd_s cmd_out,
    input wire logic cmd_valid,
    input wire logic cmd_ignored,
    input wire logic write_enable_latch,
    input wire logic soft_reset
);
    // ------------------------------------------------------------
    // Last accepted opcode; an ignored byte disarms the reset pair
    // ------------------------------------------------------------
    logic [7:0] prev_op_reg;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            prev_op_reg <= 8'h00;
        end else if (cmd_valid) begin
            prev_op_reg <= cmd_out.opcode;
        end else if (cmd_ignored) begin
            prev_op_reg <= 8'h00;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    a_pulse_exclusive: assert property (!(cmd_valid && cmd_ignored))
        else $error("valid and ignored pulsed together");
    a_valid_single: assert property (cmd_valid |=> !cmd_valid [*3])
        else $error("command valid longer than one cycle");
    a_out_cause: assert property ($changed(cmd_out) |-> cmd_valid)
        else $error("descriptor changed without valid");
    a_wel_set: assert property (
        cmd_valid && cmd_out.kind == SNC_KIND_WREN |-> write_enable_latch)
        else $error("write enable did not set latch");
    a_wel_clear: assert property (
        cmd_valid && cmd_out.kind == SNC_KIND_WRDI |-> !write_enable_latch)
        else $error("write disable did not clear latch");
    a_wel_cause: assert property (
        $rose(write_enable_latch) |-> cmd_valid && cmd_out.opcode == `SNC_OP_WREN)
        else $error("latch rose without write enable");
    // The latch clears one cycle after the reset pulse, not with it
    a_reset_pair: assert property (soft_reset |-> cmd_valid
        && cmd_out.opcode == `SNC_OP_RSTMEM && prev_op_reg == `SNC_OP_RSTEN
        ##1 !write_enable_latch)
        else $error("soft reset without armed pair");
    a_reset_armed: assert property (cmd_valid && cmd_out.opcode == `SNC_OP_RSTMEM
        && prev_op_reg == `SNC_OP_RSTEN |-> soft_reset)
        else $error("armed pair gave no soft reset");
    a_var_addr: assert property (cmd_valid && cmd_out.opcode == `SNC_OP_QIO |->
        cmd_out.addr_bytes == (four_byte_addr ? 3'h4 : 3'h3) && cmd_out.dummy == 4'hA)
        else $error("variable address count wrong");
    a_ext_read: assert property (cmd_valid && cmd_out.opcode == `SNC_OP_READ |->
        mode == SNC_MODE_EXT && cmd_out.dummy == 4'h0)
        else $error("plain read accepted outside extended mode");
    a_reg_plain: assert property (cmd_valid && cmd_out.kind == SNC_KIND_REG_READ
        && cmd_out.opcode != `SNC_OP_RD_GP |-> cmd_out.addr_bytes == 3'h0
        && cmd_out.dummy == 4'h0)
        else $error("register read with address or dummy");
endmodule // snc_decoder_checker

bind snc_decoder snc_decoder_checker i_snc_decoder_checker (.clock(clock), .nrst(nrst),
    .mode(mode), .four_byte_addr(four_byte_addr), .cmd_out(cmd_out), .cmd_valid(cmd_valid),
    .cmd_ignored(cmd_ignored), .write_enable_latch(write_enable_latch), .soft_reset(soft_reset));

// *** dv/snc_decoder_tb_top.sv ***
// Self-checking bench of the serial NOR command decoder
`timescale 1ns/1ps
`include "snc_consts.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("Error at %0t ns: got %0h expected %0h", $time, (g), (e)); end end
module snc_decoder_tb_top
    import snc_pkg::*;
;
    typedef struct packed {
        logic [1:0] m;
        logic fb;
        snc_cmd_s e;
    } snc_row_s;

    logic clock = 1'b0;
    logic nrst;
    snc_mode_e mode = SNC_MODE_EXT;
    logic four_byte_addr = 1'b0;
    wire logic link_sclk;
    wire logic link_cs_n;
    wire logic [3:0] link_dq_in;
    snc_cmd_s cmd_out;
    snc_cmd_s exp_cmd;
    logic cmd_valid;
    logic cmd_ignored;
    logic write_enable_latch;
    logic soft_reset;
    logic got_v;
    logic got_i;
    logic got_sr;
    int errors = 0;
    int n_compared = 0;
    snc_row_s rows[$];
    logic [7:0] reg_ops[6] = '{8'h05, 8'h70, 8'hB5, 8'h85, 8'h65, 8'hC8};

    always #50 clock = ~clock;

    snc_host_model i_snc_host_model (.link_sclk(link_sclk), .link_cs_n(link_cs_n),
        .link_dq_in(link_dq_in));
    snc_decoder i_snc_decoder (.clock(clock), .nrst(nrst), .mode(mode),
        .four_byte_addr(four_byte_addr), .link_sclk(link_sclk), .link_cs_n(link_cs_n),
        .link_dq_in(link_dq_in), .cmd_out(cmd_out), .cmd_valid(cmd_valid),
        .cmd_ignored(cmd_ignored), .write_enable_latch(write_enable_latch),
        .soft_reset(soft_reset));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] lw(input logic [1:0] m);
        return (m == 2'h0) ? 3'h1 : (m == 2'h1) ? 3'h2 : 3'h4;
    endfunction

    // Lanes packed as command, address, data digits; kind 0 means ignored
    function automatic void r(input logic [1:0] m, input logic fb, input logic [7:0] op,
        input logic [3:0] k, input logic dt, input logic [11:0] cad, input logic [2:0] ab,
        input logic [3:0] dm);
        rows.push_back({m, fb, op, k, dt, cad[10:8], cad[6:4], cad[2:0], ab, dm});
    endfunction

    task automatic results;
        if (errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Mode settles before the frame; answer is awaited under a bound
    task automatic frame(input logic [1:0] m, input logic fb, input logic [7:0] op, input int n);
        int i;
        repeat (4) @(posedge clock);
        mode <= snc_mode_e'(m);
        four_byte_addr <= fb;
        @(posedge clock);
        got_v = 1'b0;
        got_i = 1'b0;
        got_sr = 1'b0;
        // Dual and quad bytes complete early, so the answer comes while the frame still runs
        fork
            i_snc_host_model.send(op, lw(m), n);
            for (i = 0; i < 30; i++) begin
                @(posedge clock);
                #1;
                if (cmd_valid === 1'b1 || cmd_ignored === 1'b1) begin
                    got_v = cmd_valid;
                    got_i = cmd_ignored;
                    got_sr = soft_reset;
                    break;
                end
            end
        join
        if (i == 30 && n * lw(m) >= 8) begin
            errors++;
            results();
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        // Assigned at time zero so the asynchronous clear of the link toggle sees an edge
        nrst <= 1'b0;
        r(2'h0, 1'h0, 8'h5A, 4'h3, 1'h0, 12'h111, 3'h3, 4'h8);
        r(2'h2, 1'h1, 8'h5A, 4'h3, 1'h0, 12'h444, 3'h3, 4'h8);
        r(2'h1, 1'h0, 8'hAF, 4'h2, 1'h0, 12'h202, 3'h0, 4'h0);
        r(2'h1, 1'h0, 8'h9F, 4'h0, 1'h0, 12'h000, 3'h0, 4'h0);
        r(2'h0, 1'h0, 8'h9E, 4'h2, 1'h0, 12'h101, 3'h0, 4'h0);
        r(2'h1, 1'h1, 8'h3B, 4'h1, 1'h0, 12'h222, 3'h4, 4'h8);
        r(2'h2, 1'h0, 8'h3B, 4'h0, 1'h0, 12'h000, 3'h0, 4'h0);
        r(2'h0, 1'h0, 8'hBB, 4'h1, 1'h0, 12'h122, 3'h3, 4'h8);
        r(2'h2, 1'h0, 8'h6B, 4'h1, 1'h0, 12'h444, 3'h3, 4'hA);
        r(2'h0, 1'h1, 8'hEB, 4'h1, 1'h0, 12'h144, 3'h4, 4'hA);
        r(2'h1, 1'h0, 8'h3D, 4'h1, 1'h1, 12'h222, 3'h3, 4'h6);
        r(2'h0, 1'h0, 8'hBD, 4'h1, 1'h1, 12'h122, 3'h3, 4'h6);
        r(2'h2, 1'h0, 8'h6D, 4'h1, 1'h1, 12'h444, 3'h3, 4'h8);
        r(2'h0, 1'h0, 8'hED, 4'h1, 1'h1, 12'h144, 3'h3, 4'h8);
        r(2'h0, 1'h0, 8'h13, 4'h1, 1'h0, 12'h111, 3'h4, 4'h0);
        r(2'h2, 1'h0, 8'h0C, 4'h1, 1'h0, 12'h444, 3'h4, 4'hA);
        r(2'h1, 1'h0, 8'h3C, 4'h1, 1'h0, 12'h222, 3'h4, 4'h8);
        r(2'h0, 1'h0, 8'h6C, 4'h1, 1'h0, 12'h114, 3'h4, 4'h8);
        r(2'h2, 1'h0, 8'h0E, 4'h1, 1'h1, 12'h444, 3'h4, 4'h8);
        r(2'h0, 1'h1, 8'hBE, 4'h1, 1'h1, 12'h122, 3'h4, 4'h6);
        r(2'h2, 1'h0, 8'hEE, 4'h1, 1'h1, 12'h444, 3'h4, 4'h8);
        r(2'h2, 1'h0, 8'h96, 4'h4, 1'h0, 12'h404, 3'h0, 4'h8);
        r(2'h1, 1'h0, 8'hB1, 4'h5, 1'h0, 12'h202, 3'h0, 4'h0);
        r(2'h0, 1'h0, 8'h03, 4'h1, 1'h0, 12'h111, 3'h3, 4'h0);
        r(2'h1, 1'h0, 8'h03, 4'h0, 1'h0, 12'h000, 3'h0, 4'h0);
        r(2'h1, 1'h1, 8'h0B, 4'h1, 1'h0, 12'h222, 3'h4, 4'h8);
        r(2'h2, 1'h0, 8'h66, 4'h8, 1'h0, 12'h400, 3'h0, 4'h0);
        r(2'h1, 1'h0, 8'h04, 4'h7, 1'h0, 12'h200, 3'h0, 4'h0);
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        #1;
        `CHK(cmd_out, 29'h0000_0000)
        `CHK(write_enable_latch, 1'h0)
        foreach (rows[j]) begin
            frame(rows[j].m, rows[j].fb, rows[j].e.opcode, 8);
            `CHK({got_v, got_i}, {rows[j].e.kind != SNC_KIND_NONE, rows[j].e.kind == SNC_KIND_NONE})
            if (rows[j].e.kind != SNC_KIND_NONE) begin
                `CHK(cmd_out, rows[j].e)
            end
        end
        foreach (reg_ops[j]) begin
            frame(2'(j % 3), 1'h1, reg_ops[j], 8);
            exp_cmd = {reg_ops[j], SNC_KIND_REG_READ, 1'h0, lw(2'(j % 3)), 3'h0, lw(2'(j % 3)),
                3'h0, 4'h0};
            `CHK(cmd_out, exp_cmd)
        end
        // Short frame leaves the latch alone
        frame(2'h0, 1'h0, `SNC_OP_WREN, 5);
        `CHK(got_v | got_i, 1'h0)
        frame(2'h0, 1'h0, `SNC_OP_WREN, 8);
        `CHK(write_enable_latch, 1'h1)
        frame(2'h1, 1'h0, `SNC_OP_RSTEN, 8);
        `CHK(got_sr, 1'h0)
        frame(2'h1, 1'h0, `SNC_OP_RSTMEM, 8);
        `CHK({got_sr, write_enable_latch}, 2'h2)
        // Broken pair: an intervening command disarms the reset
        frame(2'h2, 1'h0, `SNC_OP_WREN, 8);
        frame(2'h2, 1'h0, `SNC_OP_RSTEN, 8);
        frame(2'h2, 1'h0, `SNC_OP_RD_STAT, 8);
        frame(2'h2, 1'h0, `SNC_OP_RSTMEM, 8);
        `CHK({got_v, got_sr, write_enable_latch}, 3'h5)
        `CHK(cmd_out.kind, SNC_KIND_RSTMEM)
        frame(2'h2, 1'h0, `SNC_OP_WRDI, 8);
        `CHK(write_enable_latch, 1'h0)
        results();
    end
endmodule // snc_decoder_tb_top

// *** dv/snc_host_model.sv ***
// Host-side link model that frames one command byte on the data lanes
`timescale 1ns/1ps
module snc_host_model (
    output logic link_sclk,
    output logic link_cs_n,
    output logic [3:0] link_dq_in
);
    // Non-blocking so the decoder sees the rise of chip select at time zero
    initial begin
        link_sclk <= 1'b0;
        link_cs_n <= 1'b1;
        link_dq_in <= 4'h5;
    end

    // ------------------------------------------------------------
    // One frame: msb first, w lanes per edge, n edges
    // ------------------------------------------------------------
    // Clock idles low between frames; unused and released lanes toggle
    // so a stale value never passes for a real sample
    task automatic send(input logic [7:0] op, input logic [2:0] w, input int n);
        logic [7:0] sh;
        sh = op;
        #37;
        link_cs_n = 1'b0;
        repeat (n) begin
            case (w)
                3'h4: link_dq_in = sh[7:4];
                3'h2: link_dq_in = {~link_dq_in[3:2], sh[7:6]};
                default: link_dq_in = {~link_dq_in[3:1], sh[7]};
            endcase
            sh = sh << w;
            #80 link_sclk = 1'b1;
            #80 link_sclk = 1'b0;
        end
        #40 link_cs_n = 1'b1;
        link_dq_in = ~link_dq_in;
    endtask
endmodule // snc_host_model
